// ==== cpd_regs.vh ====
// constants for the codec presence detector
`ifndef CPD_REGS_VH
`define CPD_REGS_VH
`define CPD_CLK_MHZ 20
`define CPD_FAST_WAIT_US 800
`define CPD_STD_WAIT_MS 600
`define CPD_FAST_WAIT_CYC (`CPD_FAST_WAIT_US * `CPD_CLK_MHZ)
`define CPD_STD_WAIT_CYC (`CPD_STD_WAIT_MS * 1000 * `CPD_CLK_MHZ)
`define CPD_FAST_BIT 14
`define CPD_VER_2_1 16'h0021
`define CPD_VER_2_2 16'h0022
`define CPD_REG_VENDOR 7'h02
`define CPD_REG_MODEM 7'h3c
`define CPD_ADDR_PRI 2'b00
`define CPD_ADDR_SEC 2'b01
`define CPD_ADDR_TER0 2'b10
`define CPD_ADDR_TER1 2'b11
`define CPD_FN_NONE 2'b00
`define CPD_FN_AUDIO 2'b01
`define CPD_FN_MODEM 2'b10
`define CPD_FN_BOTH 2'b11
`endif

// ==== cpd_codec_presence_detector.v ====
// boot sequencer that finds and classifies the attached codecs
`timescale 1ns/10ps
`include "cpd_regs.vh"
// What this block does
// - strap low: use fixed onboard codec data
// - onboard fast and v2.1/2.2: consult riser
// - onboard not fast, v2.1/2.2: standard wait
// - riser fast flag is feature word bit 14
// - riser version from config bytes 06h-07h
// - riser fast and v2.1/2.2: 800us wait
// - riser versions above 2.2 assume fast start; onboard ones consult riser
// - strap high: riser data alone decides
// - enable audio and modem functions first
// - then release link reset, watch ready
// - fast mode ready wait ends at 800us
// - standard mode ready wait ends 600ms
// - primary timeout: skip secondary and tertiary
// - secondary timeout: no secondary present
// - tertiary timeout: keep primary, secondary if ready
// - read regs 02h, 3Ch of primary codec
// - same reads of secondary at address 01b
// - tertiary reads at address 10b or 11b
// - classify audio, modem or combined codec
// - no primary: disable the link controller
// - primary found: hand functions onward
module cpd_codec_presence_detector #(
    parameter FAST_CYC = `CPD_FAST_WAIT_CYC,
    parameter STD_CYC = `CPD_STD_WAIT_CYC
) (
    input wire core_clk_in,
    input wire arst_n_in,
    input wire clk_en_in,
    input wire start_in,
    input wire onboard_codec_strap_n_in,
    input wire [15:0] onboard_version_in,
    input wire onboard_fast_in,
    input wire [15:0] riser_feature_word_in,
    input wire [15:0] riser_version_in,
    input wire [2:0] codec_ready_in,
    output reg rd_req_out,
    output reg [1:0] rd_codec_addr_out,
    output reg [6:0] rd_reg_index_out,
    input wire rd_ack_in,
    input wire [15:0] rd_data_in,
    output reg audio_en_out,
    output reg modem_en_out,
    output reg controller_en_out,
    output reg link_reset_n_out,
    output reg fast_mode_out,
    output reg [1:0] pri_fn_out,
    output reg [1:0] sec_fn_out,
    output reg [1:0] ter_fn_out,
    output reg [1:0] ter_addr_out,
    output reg done_out,
    output reg primary_found_out
);
    localparam S_IDLE = 9'h001;
    localparam S_ENABLE = 9'h002;
    localparam S_RELEASE = 9'h004;
    localparam S_WAIT = 9'h008;
    localparam S_REQ = 9'h010;
    localparam S_RESP = 9'h020;
    localparam S_NEXT = 9'h040;
    localparam S_FINISH = 9'h080;
    localparam S_DONE = 9'h100;

    ////////////////////////////////////////////////////////////////////
    // helpers
    function ver_ok;
        input [15:0] v;
        begin
            ver_ok = (v == `CPD_VER_2_1) || (v == `CPD_VER_2_2);
        end
    endfunction

    function ver_late;
        input [15:0] v;
        begin
            ver_late = (v > `CPD_VER_2_2);
        end
    endfunction

    function [1:0] classify;
        input [15:0] r02;
        input [15:0] r3c;
        begin
            classify = {r3c != 16'h0000, r02 != 16'h0000};
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // input synchronisers
    reg [2:0] rdy_s1_reg;
    reg [2:0] rdy_s2_reg;
    reg strap_s1_reg;
    reg strap_s2_reg;
    always @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rdy_s1_reg <= 3'h0;
            rdy_s2_reg <= 3'h0;
            strap_s1_reg <= 1'b1;
            strap_s2_reg <= 1'b1;
        end else if (clk_en_in) begin
            rdy_s1_reg <= codec_ready_in;
            rdy_s2_reg <= rdy_s1_reg;
            strap_s1_reg <= onboard_codec_strap_n_in;
            strap_s2_reg <= strap_s1_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // wait time selection
    reg riser_fast;
    reg fast_sel;
    always @* begin
        riser_fast = ver_late(riser_version_in) ||
            (riser_feature_word_in[`CPD_FAST_BIT] &&
            ver_ok(riser_version_in));
        if (!strap_s2_reg) begin
            if (ver_late(onboard_version_in)) begin
                fast_sel = riser_fast;
            end else if (onboard_fast_in &&
                ver_ok(onboard_version_in)) begin
                fast_sel = riser_fast;
            end else begin
                fast_sel = 1'b0;
            end
        end else begin
            fast_sel = riser_fast;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // sequencer state
    reg [8:0] state_reg;
    reg [8:0] state_next;
    reg [31:0] tmr_reg;
    reg [31:0] tmr_next;
    reg [31:0] limit_reg;
    reg [31:0] limit_next;
    reg [1:0] idx_reg;
    reg [1:0] idx_next;
    reg phase_reg;
    reg phase_next;
    reg [15:0] r02_reg;
    reg [15:0] r02_next;
    reg [2:0] seen_reg;
    reg [2:0] seen_next;
    reg [2:0] seen_now;
    reg [1:0] fn_now;

    // next values of the outputs
    reg rd_req_next;
    reg [1:0] rd_addr_next;
    reg [6:0] rd_index_next;
    reg audio_en_next;
    reg modem_en_next;
    reg ctl_en_next;
    reg link_rel_next;
    reg fast_mode_next;
    reg [1:0] pri_fn_next;
    reg [1:0] sec_fn_next;
    reg [1:0] ter_fn_next;
    reg [1:0] ter_addr_next;
    reg done_next;
    reg found_next;

    ////////////////////////////////////////////////////////////////////
    // next state and next outputs
    always @* begin
        state_next = state_reg;
        tmr_next = tmr_reg;
        limit_next = limit_reg;
        idx_next = idx_reg;
        phase_next = phase_reg;
        r02_next = r02_reg;
        seen_next = seen_reg;
        seen_now = seen_reg | rdy_s2_reg;
        fn_now = classify(r02_reg, rd_data_in);
        rd_req_next = rd_req_out;
        rd_addr_next = rd_codec_addr_out;
        rd_index_next = rd_reg_index_out;
        audio_en_next = audio_en_out;
        modem_en_next = modem_en_out;
        ctl_en_next = controller_en_out;
        link_rel_next = link_reset_n_out;
        fast_mode_next = fast_mode_out;
        pri_fn_next = pri_fn_out;
        sec_fn_next = sec_fn_out;
        ter_fn_next = ter_fn_out;
        ter_addr_next = ter_addr_out;
        done_next = done_out;
        found_next = primary_found_out;
        case (state_reg)
        S_IDLE: begin
            if (start_in) begin
                fast_mode_next = fast_sel;
                limit_next = fast_sel ? FAST_CYC : STD_CYC;
                state_next = S_ENABLE;
            end
        end
        S_ENABLE: begin
            audio_en_next = 1'h1;
            modem_en_next = 1'h1;
            ctl_en_next = 1'h1;
            state_next = S_RELEASE;
        end
        S_RELEASE: begin
            link_rel_next = 1'h1;
            tmr_next = 32'h0000_0000;
            state_next = S_WAIT;
        end
        S_WAIT: begin
            seen_next = seen_now;
            tmr_next = tmr_reg + 32'h0000_0001;
            if (&seen_now) begin
                idx_next = 2'h0;
                state_next = S_NEXT;
            end else if (tmr_reg >= limit_reg - 32'h0000_0001) begin
                idx_next = 2'h0;
                state_next = S_NEXT;
            end
        end
        S_NEXT: begin
            phase_next = 1'h0;
            if (idx_reg == 2'h3) begin
                state_next = S_FINISH;
            end else if (!seen_reg[0]) begin
                state_next = S_FINISH;
            end else if (!seen_reg[idx_reg]) begin
                idx_next = idx_reg + 2'h1;
            end else begin
                case (idx_reg)
                2'h0: rd_addr_next = `CPD_ADDR_PRI;
                2'h1: rd_addr_next = `CPD_ADDR_SEC;
                default: rd_addr_next = `CPD_ADDR_TER0;
                endcase
                state_next = S_REQ;
            end
        end
        S_REQ: begin
            rd_req_next = 1'h1;
            rd_index_next = phase_reg ? `CPD_REG_MODEM
                : `CPD_REG_VENDOR;
            state_next = S_RESP;
        end
        S_RESP: begin
            if (rd_ack_in) begin
                rd_req_next = 1'h0;
                if (!phase_reg) begin
                    r02_next = rd_data_in;
                    phase_next = 1'h1;
                    state_next = S_REQ;
                end else if (idx_reg == 2'h2 &&
                    fn_now == `CPD_FN_NONE &&
                    rd_codec_addr_out == `CPD_ADDR_TER0) begin
                    rd_addr_next = `CPD_ADDR_TER1;
                    phase_next = 1'h0;
                    state_next = S_REQ;
                end else begin
                    case (idx_reg)
                    2'h0: pri_fn_next = fn_now;
                    2'h1: sec_fn_next = fn_now;
                    default: begin
                        ter_fn_next = fn_now;
                        ter_addr_next = rd_codec_addr_out;
                    end
                    endcase
                    idx_next = idx_reg + 2'h1;
                    state_next = S_NEXT;
                end
            end
        end
        S_FINISH: begin
            found_next = seen_reg[0];
            if (!seen_reg[0]) begin
                ctl_en_next = 1'h0;
                audio_en_next = 1'h0;
                modem_en_next = 1'h0;
            end
            done_next = 1'h1;
            state_next = S_DONE;
        end
        S_DONE: begin
            state_next = S_DONE;
        end
        default: begin
            state_next = S_IDLE;
        end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // sequencer registers
    always @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_reg <= S_IDLE;
            tmr_reg <= 32'h0000_0000;
            limit_reg <= 32'h0000_0000;
            idx_reg <= 2'h0;
            phase_reg <= 1'h0;
            r02_reg <= 16'h0000;
            seen_reg <= 3'h0;
            rd_req_out <= 1'h0;
            rd_codec_addr_out <= 2'h0;
            rd_reg_index_out <= 7'h00;
            audio_en_out <= 1'h0;
            modem_en_out <= 1'h0;
            controller_en_out <= 1'h0;
            link_reset_n_out <= 1'h0;
            fast_mode_out <= 1'h0;
            pri_fn_out <= 2'h0;
            sec_fn_out <= 2'h0;
            ter_fn_out <= 2'h0;
            ter_addr_out <= 2'h0;
            done_out <= 1'h0;
            primary_found_out <= 1'h0;
        end else if (clk_en_in) begin
            state_reg <= state_next;
            tmr_reg <= tmr_next;
            limit_reg <= limit_next;
            idx_reg <= idx_next;
            phase_reg <= phase_next;
            r02_reg <= r02_next;
            seen_reg <= seen_next;
            rd_req_out <= rd_req_next;
            rd_codec_addr_out <= rd_addr_next;
            rd_reg_index_out <= rd_index_next;
            audio_en_out <= audio_en_next;
            modem_en_out <= modem_en_next;
            controller_en_out <= ctl_en_next;
            link_reset_n_out <= link_rel_next;
            fast_mode_out <= fast_mode_next;
            pri_fn_out <= pri_fn_next;
            sec_fn_out <= sec_fn_next;
            ter_fn_out <= ter_fn_next;
            ter_addr_out <= ter_addr_next;
            done_out <= done_next;
            primary_found_out <= found_next;
        end
    end
endmodule // cpd_codec_presence_detector

// ==== cpd_checker_assertions.sv ====
// port checks for the codec presence detector
`timescale 1ns/10ps
module cpd_checker #(
    parameter FAST_CYC = 40,
    parameter STD_CYC = 200
) (
    input wire core_clk_in,
    input wire arst_n_in,
    input wire start_in,
    input wire rd_ack_in,
    input wire rd_req_out,
    input wire [6:0] rd_reg_index_out,
    input wire audio_en_out,
    input wire modem_en_out,
    input wire controller_en_out,
    input wire link_reset_n_out,
    input wire fast_mode_out,
    input wire done_out,
    input wire primary_found_out
);
    localparam int FAST_LIM = FAST_CYC + 20;
    localparam int STD_LIM = STD_CYC + 20;
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!arst_n_in);
    chk_en_before_link: assert property (
        $rose(link_reset_n_out) |-> audio_en_out && modem_en_out
        && controller_en_out) else $error("link released before enables");
    chk_start_to_en: assert property (
        $rose(audio_en_out) |-> $past(start_in, 2))
        else $error("enables without a start");
    chk_link_after_en: assert property (
        $rose(audio_en_out) |-> !link_reset_n_out ##1 link_reset_n_out)
        else $error("link release not one cycle after enables");
    chk_req_holds: assert property (
        rd_req_out && !rd_ack_in |=> rd_req_out
        && $stable(rd_reg_index_out)) else $error("read dropped early");
    chk_index_legal: assert property (
        rd_req_out |-> link_reset_n_out && (rd_reg_index_out == 7'h02
        || rd_reg_index_out == 7'h3c)) else $error("bad read index");
    chk_pair_order: assert property (
        rd_req_out && rd_ack_in && rd_reg_index_out == 7'h02 |-> ##[1:3]
        (rd_req_out && rd_reg_index_out == 7'h3c))
        else $error("second register not read");
    chk_fast_bound: assert property (
        $rose(link_reset_n_out) && fast_mode_out |-> ##[1:FAST_LIM]
        (rd_req_out || done_out)) else $error("fast wait too long");
    chk_std_bound: assert property (
        $rose(link_reset_n_out) && !fast_mode_out |-> ##[1:STD_LIM]
        (rd_req_out || done_out)) else $error("standard wait too long");
    chk_no_pri_off: assert property (
        done_out && !primary_found_out |-> !controller_en_out
        && !audio_en_out && !modem_en_out) else $error("controller left on");
    chk_done_sticks: assert property (
        done_out |=> done_out) else $error("done dropped");
endmodule // cpd_checker
bind cpd_codec_presence_detector cpd_checker #(.FAST_CYC(FAST_CYC),
    .STD_CYC(STD_CYC)) u_chk (.core_clk_in(core_clk_in),
    .arst_n_in(arst_n_in), .start_in(start_in), .rd_ack_in(rd_ack_in),
    .rd_req_out(rd_req_out), .rd_reg_index_out(rd_reg_index_out),
    .audio_en_out(audio_en_out), .modem_en_out(modem_en_out),
    .controller_en_out(controller_en_out), .done_out(done_out),
    .link_reset_n_out(link_reset_n_out), .fast_mode_out(fast_mode_out),
    .primary_found_out(primary_found_out));

// ==== cpd_codec_model.sv ====
// codec side model: ready levels and register answers
`timescale 1ns/10ps
module cpd_codec_model (
    input wire clk_in,
    input wire link_reset_n_in,
    input wire [2:0] ready_mask_in,
    input wire [127:0] reg_map_in,
    input wire rd_req_in,
    input wire [1:0] addr_in,
    input wire [6:0] index_in,
    output reg [2:0] ready_out = 3'h0,
    output reg rd_ack_out = 1'h0,
    output reg [15:0] rd_data_out = 16'h0000
);
    reg [3:0] cnt_reg = 4'h0;
    reg ph_reg = 1'h0;
    always @(posedge clk_in) begin
        ph_reg <= !ph_reg;
        ready_out <= 3'h0;
        rd_data_out <= ~rd_data_out;
        rd_ack_out <= rd_req_in && !rd_ack_out && ph_reg;
        if (!link_reset_n_in) cnt_reg <= 4'h0;
        else if (cnt_reg != 4'hf) cnt_reg <= cnt_reg + 4'h1;
        if (cnt_reg > 4'h4) ready_out <= ready_mask_in;
        if (rd_req_in && !rd_ack_out && ph_reg) begin
            rd_data_out <= reg_map_in[{addr_in, index_in[2], 4'h0} +: 16];
        end
    end
endmodule // cpd_codec_model

// ==== cpd_codec_presence_detector_test.sv ====
// self-checking bench for the codec presence detector
`timescale 1ns/10ps
module cpd_codec_presence_detector_test;
    localparam FAST = 40;
    localparam STD = 200;
    reg core_clk_in = 1'h0, arst_n_in = 1'h0, start_in = 1'h0;
    reg strap_n = 1'h0, ob_fast = 1'h0;
    reg [15:0] ob_ver = 16'h0000, feat = 16'h0000, r_ver = 16'h0000;
    reg [2:0] mask = 3'h0;
    reg [127:0] map = 128'h0;
    wire [2:0] rdy;
    wire [1:0] addr, pri, sec, ter, ter_a;
    wire [6:0] idx;
    wire [15:0] data;
    wire req, ack, aud, mdm, ctl, lnk, fast, done, found;
    integer error_cnt = 0, checks_done = 0, reqs = 0;
    initial forever #25 core_clk_in = ~core_clk_in;
    always @(posedge core_clk_in) if (req === 1'h1) reqs = reqs + 1;
    cpd_codec_presence_detector #(.FAST_CYC(FAST), .STD_CYC(STD)) i_dut (
        .core_clk_in(core_clk_in), .arst_n_in(arst_n_in), .clk_en_in(1'h1),
        .start_in(start_in), .onboard_codec_strap_n_in(strap_n),
        .onboard_version_in(ob_ver), .onboard_fast_in(ob_fast),
        .riser_feature_word_in(feat), .riser_version_in(r_ver),
        .codec_ready_in(rdy), .rd_req_out(req), .rd_codec_addr_out(addr),
        .rd_reg_index_out(idx), .rd_ack_in(ack), .rd_data_in(data),
        .audio_en_out(aud), .modem_en_out(mdm), .controller_en_out(ctl),
        .link_reset_n_out(lnk), .fast_mode_out(fast), .pri_fn_out(pri),
        .sec_fn_out(sec), .ter_fn_out(ter), .ter_addr_out(ter_a),
        .done_out(done), .primary_found_out(found));
    cpd_codec_model i_codec (.clk_in(core_clk_in), .link_reset_n_in(lnk),
        .ready_mask_in(mask), .reg_map_in(map), .rd_req_in(req),
        .addr_in(addr), .index_in(idx), .ready_out(rdy), .rd_ack_out(ack),
        .rd_data_out(data));
    ////////////////////////////////////////////////////////////////////////
    task give_verdict;
        begin
            $display("errors %0d checks %0d", error_cnt, checks_done);
            if (error_cnt == 0 && checks_done > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask
    task chk(input string nm, input [15:0] exp, input [15:0] got);
        begin
            checks_done = checks_done + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
            end
        end
    endtask
    task run_seq(input s, of, input [15:0] ov, f, rv, input [2:0] m);
        integer n;
        begin
            @(negedge core_clk_in);
            arst_n_in = 1'h0;
            strap_n = s;
            ob_fast = of;
            ob_ver = ov;
            feat = f;
            r_ver = rv;
            mask = m;
            repeat (3) @(negedge core_clk_in);
            arst_n_in = 1'h1;
            reqs = 0;
            repeat (3) @(negedge core_clk_in);
            start_in = 1'h1;
            @(negedge core_clk_in);
            start_in = 1'h0;
            n = 0;
            while (done !== 1'h1 && n < 2000) begin
                @(negedge core_clk_in);
                n = n + 1;
            end
            if (n == 2000) begin
                error_cnt = error_cnt + 1;
                $display("CHECK FAILED done exp 1 got %b", done);
                give_verdict;
            end
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    task fast_all_present;
        begin
            map = 128'h0000_0000_0002_0001_5a5a_0000_0000_1234;
            run_seq(1'h0, 1'h1, 16'h0021, 16'h4000, 16'h0022, 3'h7);
            chk("fast", 16'h0001, fast);
            chk("pri", 16'h0001, pri);
            chk("sec", 16'h0002, sec);
            chk("ter", 16'h0003, ter);
            chk("ter_a", 16'h0002, ter_a);
            chk("found", 16'h0001, found);
            chk("aud", 16'h0001, aud);
            chk("mdm", 16'h0001, mdm);
            chk("ctl", 16'h0001, ctl);
            chk("lnk", 16'h0001, lnk);
        end
    endtask
    task std_skip_secondary;
        begin
            map = 128'h0000_0044_0000_0000_0033_0000_0022_0011;
            run_seq(1'h0, 1'h0, 16'h0022, 16'h4000, 16'h0021, 3'h5);
            chk("fast", 16'h0000, fast);
            chk("pri", 16'h0003, pri);
            chk("sec", 16'h0000, sec);
            chk("ter", 16'h0001, ter);
            chk("ter_a", 16'h0003, ter_a);
            chk("found", 16'h0001, found);
        end
    endtask
    task no_primary;
        begin
            map = {8{16'h0101}};
            run_seq(1'h1, 1'h0, 16'h0021, 16'h0000, 16'h0023, 3'h6);
            chk("fast", 16'h0001, fast);
            chk("reads", 16'h0000, reqs[15:0]);
            chk("found", 16'h0000, found);
            chk("ctl", 16'h0000, ctl);
            chk("aud", 16'h0000, aud);
            chk("mdm", 16'h0000, mdm);
        end
    endtask
    task riser_bit_clear;
        begin
            map = 128'h0000_0000_0002_0001_5a5a_0000_0000_1234;
            run_seq(1'h1, 1'h1, 16'h0022, 16'hbfff, 16'h0021, 3'h7);
            chk("fast", 16'h0000, fast);
            chk("pri", 16'h0001, pri);
        end
    endtask
    initial begin
        fast_all_present;
        std_skip_secondary;
        no_primary;
        riser_bit_clear;
        give_verdict;
    end
endmodule // cpd_codec_presence_detector_test
